// ===== rtl/psdma_pkg.sv
// How it works
// [R01] Ninety-six byte, twenty-four word DMA buffer
// [R02] Stream bytes use buffer; register accesses bypass
// [R03] SCSI register reads on low byte lane
// [R04] Hardware handles byte alignment and boundary cases
// [R05] Scatter-gather over four-kilobyte memory pages
// [R06] Address bit six routes SCSI or DMA registers
// [R07] SCSI request moves two bytes per handshake
// [R08] Burst to memory at sixteen buffered words
// [R09] Residue below threshold still delivered
// [R10] Memory reads burst into buffer toward SCSI
// [R11] Thirty-two bit buffer narrowed to sixteen bits
// [R12] Drain applies to disconnected memory writes
// [R13] Software checks SCSI interrupt, waits flags zero
// [R14] Opcode 01 empties buffer into memory
// [R15] Drain completion sets status bit five, silently
// [R16] Stranded odd byte fetched by programmed I/O
// [R17] Drain not used for interrupted memory reads
// [R18] Software idles engine after drain completes
// [R19] Idle, program, start, idle again sequence
// [R20] Descriptor list built before descriptor transfers
// [R21] Working counters readable, read-only
// [R22] DMA registers at offsets 40h to 5Ch
// [R23] Opcodes: idle, drain, abort, start
// [R24] Command written twice, start keeps bits
// [R25] Bit seven selects direction, cleared by reset
// [R26] Stall handshakes on full or empty buffer
package psdma_pkg;

    localparam int unsigned FIFO_WORDS  = 24;
    localparam int unsigned BURST_WORDS = 16;
    localparam int unsigned PAGE_BITS   = 12;
    localparam int unsigned SEL_BIT     = 6;

    localparam logic [6:0] OFS_CMD  = 7'h40;
    localparam logic [6:0] OFS_SCNT = 7'h44;
    localparam logic [6:0] OFS_SADR = 7'h48;
    localparam logic [6:0] OFS_WCNT = 7'h4c;
    localparam logic [6:0] OFS_WADR = 7'h50;
    localparam logic [6:0] OFS_STAT = 7'h54;
    localparam logic [6:0] OFS_DLS  = 7'h58;
    localparam logic [6:0] OFS_WDC  = 7'h5c;

    localparam int unsigned CMD_DIR = 7;
    localparam int unsigned CMD_LST = 4;
    localparam logic [7:0]  CMD_WMASK = 8'hf3;
    localparam logic [7:0]  CMD_RST   = 8'h00;

    localparam int unsigned ST_ABORT = 1;
    localparam int unsigned ST_DONE  = 3;
    localparam int unsigned ST_SIRQ  = 4;
    localparam int unsigned ST_DRAIN = 5;

    typedef enum logic [1:0] {
        OP_IDLE  = 2'b00,
        OP_DRAIN = 2'b01,
        OP_ABORT = 2'b10,
        OP_START = 2'b11
    } psdma_op_t;

    typedef enum logic [2:0] {
        S_IDLE, S_DESC, S_RUN, S_WLOAD, S_WBEAT, S_RBEAT, S_END
    } psdma_state_t;

    typedef struct packed {
        logic        write;
        logic [31:0] addr;
        logic [31:0] wdata;
        logic [3:0]  be;
    } psdma_mem_t;

endpackage

// ===== rtl/psdma_fifo.sv
`timescale 1ns/1ps
module psdma_fifo #(
    parameter int unsigned W     = 32,
    parameter int unsigned DEPTH = 24
) (
    input  wire logic                       core_clk,
    input  wire logic                       srst,
    input  wire logic                       clr,
    input  wire logic                       in_valid,
    output logic                            in_ready,
    input  wire logic [W-1:0]               in_data,
    output logic                            out_valid,
    input  wire logic                       out_ready,
    output logic [W-1:0]                    out_data,
    output logic [$clog2(DEPTH+1)-1:0]      level
);
    localparam int unsigned AW = $clog2(DEPTH);

    initial begin
        if (DEPTH < 2) $error("psdma_fifo depth below two");
    end

    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [$clog2(DEPTH+1)-1:0] cnt_r;
    logic push;
    logic pop;

    assign in_ready  = (cnt_r != DEPTH[$clog2(DEPTH+1)-1:0]);
    assign out_valid = (cnt_r != '0);
    assign out_data  = mem[rp_r];
    assign level     = cnt_r;
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wp_r] <= in_data;
        end
    end

    // Non-power-of-two depth, so pointers wrap explicitly
    always_ff @(posedge core_clk) begin
        if (srst | clr) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wp_r <= (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
            end
            cnt_r <= cnt_r + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0);
        end
    end

    a_fifo_bound: assert property (@(posedge core_clk) disable iff (srst)
        !(push && cnt_r == DEPTH[$clog2(DEPTH+1)-1:0]) && cnt_r <= DEPTH)
        else $error("buffer over its depth"); // [R01]
endmodule // psdma_fifo

// ===== rtl/psdma_top.sv
`timescale 1ns/1ps
module psdma_top #(
    parameter int unsigned DEPTH = psdma_pkg::FIFO_WORDS,
    parameter int unsigned BURST = psdma_pkg::BURST_WORDS
) (
    input  wire logic                 core_clk,
    input  wire logic                 srst,
    input  wire logic                 reg_valid,
    input  wire logic                 reg_write,
    input  wire logic [6:0]           reg_addr,
    input  wire logic [31:0]          reg_wdata,
    input  wire logic [3:0]           reg_be,
    output logic                      reg_ack_r,
    output logic [31:0]               reg_rdata_r,
    output logic                      scsi_cs_r,
    output logic                      scsi_rd_r,
    output logic                      scsi_wr_r,
    output logic [3:0]                scsi_addr_r,
    output logic [7:0]                scsi_wdata_r,
    input  wire logic [7:0]           scsi_rdata,
    input  wire logic                 scsi_irq,
    input  wire logic                 transfer_request,
    input  wire logic [15:0]          scsi_din,
    output logic                      transfer_acknowledge_r,
    output logic [15:0]               scsi_dout_r,
    output logic                      mem_req_r,
    output psdma_pkg::psdma_mem_t     mem_cmd_r,
    input  wire logic                 mem_ack,
    input  wire logic [31:0]          mem_rdata
);
    localparam int unsigned LW = $clog2(DEPTH + 1);

    initial begin
        if (BURST < 1 || BURST > DEPTH) $error("burst must fit the buffer");
    end

    psdma_pkg::psdma_state_t state_r;
    logic [7:0]  cmd_r;
    logic [23:0] scnt_r;
    logic [31:0] sadr_r;
    logic [31:0] dls_r;
    logic [23:0] wcnt_r;
    logic [31:0] wadr_r;
    logic [31:0] wdc_r;
    logic        done_r;
    logic        abort_r;
    logic        drain_done_r;
    logic        drain_r;
    logic        need_desc_r;
    logic        first_r;
    logic [4:0]  beats_r;
    logic        scsi_pend_r;
    logic [15:0] half_r;
    logic        half_v_r;
    logic        fin_valid;
    logic        fin_ready;
    logic [31:0] fin_data;
    logic        fout_valid;
    logic        fout_ready;
    logic [31:0] fout_data;
    logic [LW-1:0] level;
    logic        fclr;
    logic [31:0] status;

    wire dir_r     = cmd_r[psdma_pkg::CMD_DIR];
    wire lst_r     = cmd_r[psdma_pkg::CMD_LST];
    wire run       = (state_r != psdma_pkg::S_IDLE);
    wire dma_sel   = reg_addr[psdma_pkg::SEL_BIT];
    wire wr_dma    = reg_valid & reg_write & dma_sel;
    wire op_wr     = wr_dma & reg_be[0] & (reg_addr == psdma_pkg::OFS_CMD);
    wire [1:0] op  = reg_wdata[1:0];
    wire page_end  = (wadr_r[psdma_pkg::PAGE_BITS-1:2] == '1);
    wire last_word = (wcnt_r <= 24'h000004);
    wire scsi_take = transfer_acknowledge_r & dir_r;
    wire pad_push  = drain_r & half_v_r & ~scsi_take;

    function automatic logic [31:0] merge(input logic [31:0] o,
                                          input logic [31:0] n,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) r[8*i +: 8] = n[8*i +: 8];
        end
        return r;
    endfunction

    // Final partial word carries only its live byte lanes
    function automatic logic [3:0] tail_be(input logic [23:0] n);
        logic [3:0] r;
        r = 4'hf;
        if (n < 24'h000004) begin
            unique case (n[1:0])
                2'h1: r = 4'h1;
                2'h2: r = 4'h3;
                2'h3: r = 4'h7;
                2'h0: r = 4'h0;
            endcase
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Buffer and funnel

    psdma_fifo #(
        .W     (32),
        .DEPTH (DEPTH)
    ) u_fifo (
        .core_clk  (core_clk),
        .srst      (srst),
        .clr       (fclr),
        .in_valid  (fin_valid),
        .in_ready  (fin_ready),
        .in_data   (fin_data),
        .out_valid (fout_valid),
        .out_ready (fout_ready),
        .out_data  (fout_data),
        .level     (level)
    ); // [R01]

    assign fclr = op_wr & (op == psdma_pkg::OP_ABORT) & run;
    // Stream from either side, never from register traffic
    assign fin_valid = dir_r ? ((scsi_take & half_v_r) | pad_push)
                             : (state_r == psdma_pkg::S_RBEAT & mem_ack); // [R02]
    assign fin_data  = dir_r ? {(scsi_take ? scsi_din : 16'h0000), half_r}
                             : mem_rdata; // [R11]
    assign fout_ready = dir_r ? (state_r == psdma_pkg::S_WLOAD)
        : (run & transfer_request & ~transfer_acknowledge_r & ~half_v_r);

    // One cycle gap after every acknowledge keeps the request sampled fresh
    always_ff @(posedge core_clk) begin
        if (srst) begin
            transfer_acknowledge_r <= 1'b0;
        end else if (dir_r) begin
            transfer_acknowledge_r <= run & transfer_request & ~drain_r
                & ~transfer_acknowledge_r & (~half_v_r | fin_ready); // [R07] [R26]
        end else begin
            transfer_acknowledge_r <= run & transfer_request
                & ~transfer_acknowledge_r & (half_v_r | fout_valid); // [R26]
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst | fclr) begin
            half_r      <= 16'h0000;
            half_v_r    <= 1'b0;
            scsi_dout_r <= 16'h0000;
        end else if (dir_r) begin
            if (scsi_take) begin
                half_r   <= scsi_din;
                half_v_r <= ~half_v_r; // [R11]
            end else if (pad_push & fin_ready) begin
                half_v_r <= 1'b0; // [R04]
            end
        end else if (run & transfer_request & ~transfer_acknowledge_r) begin
            if (half_v_r) begin
                scsi_dout_r <= half_r;
                half_v_r    <= 1'b0; // [R11]
            end else if (fout_valid) begin
                scsi_dout_r <= fout_data[15:0];
                half_r      <= fout_data[31:16];
                half_v_r    <= 1'b1; // [R10]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register decode and read-back

    always_ff @(posedge core_clk) begin
        if (srst) begin
            cmd_r <= psdma_pkg::CMD_RST; // [R25]
            scnt_r <= '0;
            sadr_r <= '0;
            dls_r <= '0;
        end else if (wr_dma) begin
            unique case (reg_addr)
                psdma_pkg::OFS_CMD: if (reg_be[0]) begin
                    cmd_r <= reg_wdata[7:0] & psdma_pkg::CMD_WMASK; // [R23]
                end
                psdma_pkg::OFS_SCNT: scnt_r <= 24'(merge({8'h00, scnt_r},
                                                 reg_wdata, reg_be));
                psdma_pkg::OFS_SADR: sadr_r <= merge(sadr_r, reg_wdata,
                                                     reg_be);
                psdma_pkg::OFS_DLS: dls_r <= merge(dls_r, reg_wdata, reg_be);
                default: ;
            endcase
        end
    end

    always_comb begin
        status = 32'h0;
        status[psdma_pkg::ST_ABORT] = abort_r;
        status[psdma_pkg::ST_DONE]  = done_r;
        status[psdma_pkg::ST_SIRQ]  = scsi_irq; // [R13]
        status[psdma_pkg::ST_DRAIN] = drain_done_r; // [R15]
    end

    // SCSI register accesses skip the buffer and answer two cycles after the request
    always_ff @(posedge core_clk) begin
        if (srst) begin
            scsi_cs_r    <= 1'b0;
            scsi_rd_r    <= 1'b0;
            scsi_wr_r    <= 1'b0;
            scsi_addr_r  <= 4'h0;
            scsi_wdata_r <= 8'h00;
            scsi_pend_r  <= 1'b0;
            reg_ack_r    <= 1'b0;
            reg_rdata_r  <= 32'h0;
        end else begin
            scsi_cs_r    <= reg_valid & ~dma_sel; // [R06]
            scsi_rd_r    <= reg_valid & ~dma_sel & ~reg_write;
            scsi_wr_r    <= reg_valid & ~dma_sel & reg_write;
            scsi_addr_r  <= reg_addr[5:2];
            scsi_wdata_r <= reg_wdata[7:0];
            scsi_pend_r  <= reg_valid & ~dma_sel;
            reg_ack_r    <= (reg_valid & dma_sel) | scsi_pend_r;
            if (scsi_pend_r) begin
                reg_rdata_r <= {24'h000000, scsi_rd_r ? scsi_rdata
                                                      : 8'h00}; // [R03]
            end else if (reg_valid & dma_sel & ~reg_write) begin
                unique case (reg_addr)
                    psdma_pkg::OFS_CMD:  reg_rdata_r <= {24'h0, cmd_r};
                    psdma_pkg::OFS_SCNT: reg_rdata_r <= {8'h0, scnt_r};
                    psdma_pkg::OFS_SADR: reg_rdata_r <= sadr_r;
                    psdma_pkg::OFS_WCNT: reg_rdata_r <= {8'h0, wcnt_r}; // [R21]
                    psdma_pkg::OFS_WADR: reg_rdata_r <= wadr_r; // [R21]
                    psdma_pkg::OFS_STAT: reg_rdata_r <= status;
                    psdma_pkg::OFS_DLS:  reg_rdata_r <= dls_r;
                    psdma_pkg::OFS_WDC:  reg_rdata_r <= wdc_r; // [R21]
                    default:             reg_rdata_r <= 32'h0; // [R22]
                endcase
            end else begin
                reg_rdata_r <= 32'h0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Engine

    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_r      <= psdma_pkg::S_IDLE;
            wcnt_r <= '0;
            wadr_r <= '0;
            wdc_r <= '0;
            done_r <= 1'b0;
            abort_r <= 1'b0;
            drain_done_r <= 1'b0;
            drain_r      <= 1'b0;
            need_desc_r  <= 1'b0;
            first_r      <= 1'b0;
            beats_r      <= '0;
            mem_req_r    <= 1'b0;
            mem_cmd_r    <= '0;
        end else if (op_wr & (op == psdma_pkg::OP_ABORT) & run) begin
            state_r   <= psdma_pkg::S_IDLE; // [R23]
            abort_r   <= 1'b1;
            drain_r   <= 1'b0;
            mem_req_r <= 1'b0;
        end else if (op_wr & (op == psdma_pkg::OP_START) & ~run) begin
            wcnt_r       <= scnt_r; // [R23]
            wadr_r       <= sadr_r;
            wdc_r        <= dls_r;
            need_desc_r  <= reg_wdata[psdma_pkg::CMD_LST];
            first_r      <= 1'b1;
            done_r <= 1'b0;
            abort_r <= 1'b0;
            drain_done_r <= 1'b0;
            state_r      <= psdma_pkg::S_RUN;
        end else if (op_wr & (op == psdma_pkg::OP_IDLE)) begin
            state_r   <= psdma_pkg::S_IDLE;
            drain_r   <= 1'b0;
            mem_req_r <= 1'b0;
        end else begin
            if (op_wr & (op == psdma_pkg::OP_DRAIN) & dir_r & run) begin
                drain_r <= 1'b1; // [R14] [R12]
            end
            unique case (state_r)
                psdma_pkg::S_IDLE: ;
                psdma_pkg::S_END: done_r <= 1'b1;
                psdma_pkg::S_RUN: begin
                    beats_r <= '0;
                    if (wcnt_r == '0) begin
                        state_r <= psdma_pkg::S_END;
                    end else if (need_desc_r & lst_r) begin
                        mem_req_r       <= 1'b1; // [R05]
                        mem_cmd_r.write <= 1'b0;
                        mem_cmd_r.addr  <= wdc_r;
                        mem_cmd_r.be    <= 4'hf;
                        state_r         <= psdma_pkg::S_DESC;
                    end else if (dir_r) begin
                        if (level >= LW'(BURST) // [R08]
                            || (level != '0 && {level, 2'b00} >= wcnt_r)
                            || (drain_r && level != '0)) begin // [R09]
                            state_r <= psdma_pkg::S_WLOAD;
                        end else if (drain_r & ~half_v_r) begin
                            drain_r      <= 1'b0;
                            drain_done_r <= 1'b1; // [R15]
                        end
                    end else if (level < LW'(DEPTH)) begin
                        mem_req_r       <= 1'b1; // [R10]
                        mem_cmd_r.write <= 1'b0;
                        mem_cmd_r.addr  <= wadr_r;
                        mem_cmd_r.be    <= tail_be(wcnt_r);
                        state_r         <= psdma_pkg::S_RBEAT;
                    end
                end
                psdma_pkg::S_DESC: if (mem_ack) begin
                    mem_req_r   <= 1'b0;
                    wadr_r      <= {mem_rdata[31:psdma_pkg::PAGE_BITS],
                        first_r ? sadr_r[psdma_pkg::PAGE_BITS-1:0]
                                : 12'h000}; // [R05]
                    wdc_r       <= wdc_r + 32'h4;
                    first_r     <= 1'b0;
                    need_desc_r <= 1'b0;
                    state_r     <= psdma_pkg::S_RUN;
                end
                psdma_pkg::S_WLOAD: begin
                    mem_req_r       <= 1'b1;
                    mem_cmd_r.write <= 1'b1;
                    mem_cmd_r.addr  <= wadr_r;
                    mem_cmd_r.wdata <= fout_data;
                    mem_cmd_r.be    <= tail_be(wcnt_r); // [R04]
                    state_r         <= psdma_pkg::S_WBEAT;
                end
                psdma_pkg::S_WBEAT, psdma_pkg::S_RBEAT: if (mem_ack) begin
                    wadr_r      <= wadr_r + 32'h4;
                    wcnt_r      <= last_word ? 24'h0 : wcnt_r - 24'h4;
                    beats_r     <= beats_r + 5'h1;
                    need_desc_r <= page_end; // [R05]
                    mem_cmd_r.addr <= wadr_r + 32'h4;
                    mem_cmd_r.be   <= tail_be(last_word ? 24'h0
                                                        : wcnt_r - 24'h4);
                    // Bursts stop at page ends so the next page is looked up
                    if (state_r == psdma_pkg::S_WBEAT) begin
                        mem_req_r <= 1'b0;
                        state_r   <= (32'(beats_r) + 1 < BURST && level != '0
                            && !last_word && !page_end)
                            ? psdma_pkg::S_WLOAD : psdma_pkg::S_RUN; // [R08]
                    end else if (!(32'(beats_r) + 1 < BURST && !last_word
                                   && !page_end
                                   && 32'(level) + 1 < DEPTH)) begin
                        mem_req_r <= 1'b0; // [R26]
                        state_r   <= psdma_pkg::S_RUN;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    a_route_scsi: assert property (@(posedge core_clk) disable iff (srst)
        reg_valid && !dma_sel |=> scsi_cs_r ##1 reg_ack_r) // [R06]
        else $error("SCSI access not routed");
    a_route_dma: assert property (@(posedge core_clk) disable iff (srst)
        reg_valid && dma_sel |=> reg_ack_r && !scsi_cs_r) // [R06]
        else $error("DMA access not routed");
    a_scsi_lane: assert property (@(posedge core_clk) disable iff (srst)
        scsi_pend_r |=> reg_rdata_r[31:8] == 24'h0) // [R03]
        else $error("upper lanes not null");
    a_full_stall: assert property (@(posedge core_clk) disable iff (srst)
        scsi_take && half_v_r |-> fin_ready) // [R26]
        else $error("SCSI word lost at full buffer");
    a_burst_len: assert property (@(posedge core_clk) disable iff (srst)
        32'(beats_r) <= BURST) // [R08]
        else $error("burst longer than threshold");
    a_drain_done: assert property (@(posedge core_clk) disable iff (srst)
        $rose(drain_done_r) |-> level == '0 && !half_v_r) // [R15]
        else $error("drain flagged with data left");
    a_abort_op: assert property (@(posedge core_clk) disable iff (srst)
        op_wr && op == psdma_pkg::OP_ABORT && run
        |=> state_r == psdma_pkg::S_IDLE && abort_r && level == '0) // [R23]
        else $error("abort not taken");
    a_start_load: assert property (@(posedge core_clk) disable iff (srst)
        op_wr && op == psdma_pkg::OP_START && !run
        |=> wcnt_r == $past(scnt_r) && state_r == psdma_pkg::S_RUN) // [R23]
        else $error("start did not load counters");
    a_narrow: assert property (@(posedge core_clk) disable iff (srst)
        transfer_acknowledge_r && !dir_r
        |-> $past(half_v_r) || $past(fout_valid)) // [R11]
        else $error("SCSI fed from empty buffer");
endmodule // psdma_top

// ===== testbench/psdma_mem_model.sv
`timescale 1ns/1ps
module psdma_mem_model (
    input  wire logic                 core_clk,
    input  wire logic                 srst,
    input  wire logic                 mem_req_r,
    input  wire psdma_pkg::psdma_mem_t mem_cmd_r,
    output logic                      mem_ack,
    output logic [31:0]               mem_rdata
);
    logic [31:0] mem [0:63];
    logic        slow_r;
    // Alternates prompt and one-cycle-late answers
    always_ff @(posedge core_clk) begin
        slow_r    <= srst ? 1'h0 : ~slow_r;
        mem_ack   <= 1'h0;
        mem_rdata <= srst ? 32'h0 : ~mem_rdata;
        if (!srst && mem_req_r && !mem_ack && slow_r) begin
            mem_ack <= 1'h1;
            if (mem_cmd_r.write) begin
                mem[mem_cmd_r.addr[7:2]] <= mem_cmd_r.wdata;
            end else begin
                mem_rdata <= mem_cmd_r.addr ^ 32'ha5a50000;
            end
        end
    end
endmodule // psdma_mem_model

// ===== testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
    typedef struct packed {
        logic        wr;
        logic [6:0]  a;
        logic [31:0] d;
    } psdma_row_t;
    logic core_clk = 1'h0, srst = 1'h1, reg_valid = 1'h0, reg_write = 1'h0;
    logic scsi_irq = 1'h0, transfer_request = 1'h0, mem_ack;
    logic [6:0] reg_addr = 7'h0;
    logic [31:0] reg_wdata = 32'h0, mem_rdata, q;
    logic [3:0] reg_be = 4'hf;
    logic [7:0] scsi_rdata = 8'h3c;
    logic [15:0] scsi_din = 16'h0;
    logic reg_ack_r, scsi_cs_r, scsi_rd_r, scsi_wr_r;
    logic transfer_acknowledge_r, mem_req_r;
    logic [31:0] reg_rdata_r;
    logic [3:0] scsi_addr_r;
    logic [7:0] scsi_wdata_r;
    logic [15:0] scsi_dout_r;
    psdma_pkg::psdma_mem_t mem_cmd_r;
    int errors = 0, num_checks = 0;
    psdma_row_t rows [11] = '{'{1'h0,7'h40,32'h0}, '{1'h1,7'h44,32'h40},
        '{1'h0,7'h44,32'h40}, '{1'h1,7'h48,32'h1000}, '{1'h0,7'h48,32'h1000},
        '{1'h1,7'h58,32'h2000}, '{1'h0,7'h58,32'h2000},
        '{1'h1,7'h54,32'hffffffff}, '{1'h0,7'h54,32'h0},
        '{1'h0,7'h60,32'h0}, '{1'h1,7'h40,32'h8c}};
    always #12.5 core_clk = ~core_clk;
    psdma_top dut (.core_clk, .srst, .reg_valid, .reg_write, .reg_addr,
        .reg_wdata, .reg_be, .reg_ack_r, .reg_rdata_r, .scsi_cs_r,
        .scsi_rd_r, .scsi_wr_r, .scsi_addr_r, .scsi_wdata_r, .scsi_rdata,
        .scsi_irq, .transfer_request, .scsi_din, .transfer_acknowledge_r,
        .scsi_dout_r, .mem_req_r, .mem_cmd_r, .mem_ack, .mem_rdata);
    psdma_mem_model u_mem (.core_clk, .srst, .mem_req_r, .mem_cmd_r,
        .mem_ack, .mem_rdata);
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic rw(input logic w, input logic [6:0] a,
                      input logic [31:0] d);
        int n;
        @(negedge core_clk);
        {reg_valid, reg_write, reg_addr, reg_wdata} = {1'h1, w, a, d};
        @(negedge core_clk);
        reg_valid = 1'h0;
        for (n = 0; reg_ack_r !== 1'h1 && n < 8; n++) @(negedge core_clk);
        q = reg_rdata_r;
        if (n == 8) errors++;
    endtask
    task automatic poll(input int b);
        int n;
        for (n = 0; n < 300; n++) begin
            rw(1'h0, 7'h54, 32'h0);
            if (q[b] === 1'h1) break;
        end
    endtask
    // Data changes only after the ack cycle has ended
    task automatic feed(input logic rd, input int n, input logic [15:0] ba);
        int i;
        int t;
        i = 0;
        @(negedge core_clk);
        scsi_din = 16'h1100;
        transfer_request = 1'h1;
        for (t = 0; i < n && t < 4000; t++) begin
            @(negedge core_clk);
            if (transfer_acknowledge_r === 1'h1) begin
                if (rd) chk({16'h0, scsi_dout_r}, {16'h0, i[0] ? 16'ha5a5 :
                    ba + 16'(4 * (i / 2))});
                i++;
                if (i == n) transfer_request = 1'h0;
                @(negedge core_clk);
                scsi_din = 16'h1100 + 16'(i);
            end
        end
        scsi_din = ~scsi_din;
        if (t == 4000) errors++;
    endtask
    task automatic memchk(input int at, input int n);
        for (int j = 0; j < n; j++)
            chk(u_mem.mem[at + j], {16'h1101 + 16'(2 * j),
                16'h1100 + 16'(2 * j)});
    endtask
    task automatic print_verdict();
        if (errors == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        #500000;
        errors++;
        print_verdict();
    end
    initial begin
        repeat (3) @(negedge core_clk);
        srst = 1'h0;
        foreach (rows[i]) begin
            rw(rows[i].wr, rows[i].a, rows[i].d);
            if (!rows[i].wr) chk(q, rows[i].d);
        end
        rw(1'h0, 7'h40, 32'h0);
        chk(q, 32'h80);
        rw(1'h0, 7'h08, 32'h0);
        chk(q, 32'h3c);
        rw(1'h1, 7'h40, 32'h83);
        feed(1'h0, 32, 16'h0);
        poll(3);
        memchk(0, 16);
        rw(1'h0, 7'h4c, 32'h0);
        chk(q, 32'h0);
        rw(1'h1, 7'h40, 32'h80);
        scsi_irq = 1'h1;
        rw(1'h1, 7'h48, 32'h1040);
        rw(1'h1, 7'h40, 32'h83);
        feed(1'h0, 6, 16'h0);
        rw(1'h1, 7'h40, 32'h81);
        poll(5);
        chk(q & 32'h38, 32'h30);
        memchk(16, 3);
        rw(1'h1, 7'h40, 32'h80);
        scsi_irq = 1'h0;
        rw(1'h1, 7'h40, 32'h0);
        rw(1'h1, 7'h44, 32'h8);
        rw(1'h1, 7'h48, 32'h1080);
        rw(1'h1, 7'h40, 32'h3);
        feed(1'h1, 4, 16'h1080);
        poll(3);
        chk(q & 32'h8, 32'h8);
        rw(1'h1, 7'h40, 32'h0);
        rw(1'h1, 7'h44, 32'h4);
        rw(1'h1, 7'h58, 32'h20f0);
        rw(1'h1, 7'h40, 32'h90);
        rw(1'h1, 7'h40, 32'h93);
        feed(1'h0, 2, 16'h0);
        poll(3);
        memchk(32, 1);
        rw(1'h0, 7'h5c, 32'h0);
        chk(q, 32'h20f4);
        rw(1'h1, 7'h40, 32'h80);
        rw(1'h1, 7'h44, 32'h8);
        rw(1'h1, 7'h40, 32'h83);
        feed(1'h0, 2, 16'h0);
        rw(1'h1, 7'h40, 32'h82);
        rw(1'h0, 7'h54, 32'h0);
        chk(q & 32'ha, 32'h2);
        rw(1'h1, 7'h40, 32'h80);
        print_verdict();
    end
endmodule // testbench
